// *** rtl/tvr_pkg.sv ***
// Shared constants and types for the tank vent recovery sequencer.
package tvr_pkg;

	// Clock rate and the overpressure dwell time.
	localparam longint CLK_HZ            = 10_000_000;
	localparam longint OVERPRESS_TIME_S  = 5 * 60;
	localparam longint OVERPRESS_CYCLES  = OVERPRESS_TIME_S * CLK_HZ;

	// Register port geometry.
	localparam int     ADDR_W            = 4;
	localparam int     DATA_W            = 32;

	// Register offsets (byte addresses).
	localparam logic [3:0] CTRL_OFS      = 4'h0;
	localparam logic [3:0] STATUS_OFS    = 4'h4;

	// Control register fields and reset value.
	localparam int     CTRL_AUTO_EN_BIT  = 0;
	localparam int     CTRL_ERR_CLR_BIT  = 1;
	localparam logic   CTRL_AUTO_EN_RST  = 1'h1;

	// Status register field positions.
	localparam int     STAT_STATE_LSB    = 0;
	localparam int     STAT_EXPIRED_BIT  = 3;
	localparam int     STAT_INLET_BIT    = 4;
	localparam int     STAT_VENT_BIT     = 5;
	localparam int     STAT_CMP_IN_BIT   = 6;
	localparam int     STAT_CMP_RUN_BIT  = 7;
	localparam int     STAT_PUMP_REQ_BIT = 8;
	localparam int     STAT_ERROR_BIT    = 9;

	// Discrete switch inputs in synchroniser order.
	localparam int     SW_COLD           = 0;
	localparam int     SW_ALARM_TWO      = 1;
	localparam int     SW_ALARM_ONE      = 2;
	localparam int     SW_START          = 3;
	localparam int     SW_STOP           = 4;
	localparam int     SW_VACUUM         = 5;
	localparam int     SW_INLET_LOW      = 6;
	localparam int     SW_ACCUM          = 7;
	localparam int     SW_LOW_LEVEL      = 8;
	localparam int     SW_MID_LEVEL      = 9;
	localparam int     SW_OVERPRESS      = 10;
	localparam int     SW_CMP_PRESS      = 11;
	localparam int     SW_COUNT          = 12;

	typedef enum logic [2:0] {
		TVR_IDLE       = 3'b000,
		TVR_RECOVER    = 3'b001,
		TVR_SELF_EVAC  = 3'b010,
		TVR_INTER_VENT = 3'b011,
		TVR_FINAL_VENT = 3'b100,
		TVR_PUMP_OUT   = 3'b101,
		TVR_ERROR      = 3'b110
	} tvr_state_e;

endpackage : tvr_pkg

// *** rtl/tvr_sync.sv ***
// Two-stage synchroniser for a group of discrete switch inputs.
`timescale 1ns/1ns
`default_nettype none
module tvr_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_i,
	input  wire logic         srst_i,
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);

	logic [W-1:0] meta_reg;

	// The first stage feeds only the second stage.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			meta_reg <= '0;
			sync_o   <= '0;
		end else begin
			meta_reg <= async_i;
			sync_o   <= meta_reg;
		end
	end

endmodule : tvr_sync
`default_nettype wire

// *** rtl/tvr_sequencer.sv ***
// Recovery, self-evacuation and nitrogen vent sequencing for the agent recovery machine.
// How it works
// [RULE_01] Alarm-one low over five minutes: intermediate vent.
// [RULE_02] Overpressure switch opens: intermediate vent immediately.
// [RULE_03] Vent entry drops inlet valve and compressor.
// [RULE_04] Vent valve opens only once tank cold.
// [RULE_05] Alarm-one reasserts: intermediate vent ends, valve closes.
// [RULE_06] Mid level or empty source: final vent.
// [RULE_07] Alarm-two deasserts: final vent ends, valve closes.
// [RULE_08] Pump-out follows only with low level present.
// [RULE_09] Start button opens inlet valves.
// [RULE_10] Inlet pressure low: compressor inlet and compressor on.
// [RULE_11] Liquid in accumulator: close compressor inlet, keep compressor.
// [RULE_12] Inlet valve may stay open during self-evacuation.
// [RULE_13] Vent valve holds until done or unsuitable.
// [RULE_14] One output drives vent valve and lamp.
// [RULE_15] Stop switch opening leaves automatic mode.
// [RULE_16] Compressor pressure switch open: stop, flag error.
// [RULE_17] Alarm-one reassertion clears the overpressure timer.
// [RULE_18] Every switch input synchronised before use.
`timescale 1ns/1ns
`default_nettype none
module tvr_sequencer #(
	parameter logic [31:0] OVERPRESS_CYC = 32'(tvr_pkg::OVERPRESS_CYCLES)
) (
	input  wire logic                        clk_i,
	input  wire logic                        srst_i,
	input  wire logic                        tank_cold_alarm_in_i,
	input  wire logic                        tank_pressure_alarm_two_in_i,
	input  wire logic                        tank_pressure_alarm_one_in_i,
	input  wire logic                        start_button_in_i,
	input  wire logic                        stop_button_in_i,
	input  wire logic                        source_vacuum_in_i,
	input  wire logic                        inlet_pressure_low_in_i,
	input  wire logic                        accumulator_level_in_i,
	input  wire logic                        tank_low_level_in_i,
	input  wire logic                        tank_mid_level_in_i,
	input  wire logic                        tank_overpressure_in_i,
	input  wire logic                        compressor_pressure_fault_in_i,
	input  wire logic [tvr_pkg::ADDR_W-1:0]  reg_addr_i,
	input  wire logic [tvr_pkg::DATA_W-1:0]  reg_wdata_i,
	input  wire logic                        reg_we_i,
	input  wire logic                        reg_re_i,
	output logic      [tvr_pkg::DATA_W-1:0]  reg_rdata_o,
	output logic                             inlet_valve_out_o,
	output logic                             vent_valve_out_o,
	output logic                             compressor_inlet_valve_out_o,
	output logic                             compressor_run_out_o,
	output logic                             processing_o,
	output logic                             pump_out_request_o,
	output logic                             error_o
);
	import tvr_pkg::*;

	// Synchronised switch levels.
	logic [SW_COUNT-1:0] sw_raw;
	logic [SW_COUNT-1:0] sw;

	assign sw_raw[SW_COLD]      = tank_cold_alarm_in_i;
	assign sw_raw[SW_ALARM_TWO] = tank_pressure_alarm_two_in_i;
	assign sw_raw[SW_ALARM_ONE] = tank_pressure_alarm_one_in_i;
	assign sw_raw[SW_START]     = start_button_in_i;
	assign sw_raw[SW_STOP]      = stop_button_in_i;
	assign sw_raw[SW_VACUUM]    = source_vacuum_in_i;
	assign sw_raw[SW_INLET_LOW] = inlet_pressure_low_in_i;
	assign sw_raw[SW_ACCUM]     = accumulator_level_in_i;
	assign sw_raw[SW_LOW_LEVEL] = tank_low_level_in_i;
	assign sw_raw[SW_MID_LEVEL] = tank_mid_level_in_i;
	assign sw_raw[SW_OVERPRESS] = tank_overpressure_in_i;
	assign sw_raw[SW_CMP_PRESS] = compressor_pressure_fault_in_i;

	// Switch contacts bounce and arrive asynchronously, so nothing reads them raw.
	tvr_sync #(
		.W(SW_COUNT)
	) u_sync (
		.clk_i  (clk_i),
		.srst_i (srst_i),
		.async_i(sw_raw),
		.sync_o (sw)
	); // [RULE_18]

	// Named views of the synchronised switches.
	wire tank_cold      = sw[SW_COLD];
	wire alarm_two      = sw[SW_ALARM_TWO];
	wire alarm_one      = sw[SW_ALARM_ONE];
	wire start_press    = sw[SW_START];
	wire stop_open      = ~sw[SW_STOP];
	wire source_empty   = ~sw[SW_VACUUM];
	wire inlet_low      = sw[SW_INLET_LOW];
	wire accum_liquid   = ~sw[SW_ACCUM];
	wire low_level      = sw[SW_LOW_LEVEL];
	wire mid_level      = sw[SW_MID_LEVEL];
	wire overpress      = ~sw[SW_OVERPRESS];
	wire cmp_fault      = ~sw[SW_CMP_PRESS];

	// Software control.
	logic auto_en_reg;
	logic err_clr_reg;

	// Sequencer state and outputs.
	tvr_state_e  state_reg;
	tvr_state_e  state_next;
	logic [31:0] op_cnt_reg;
	logic [31:0] op_cnt_next;
	logic        inlet_next;
	logic        vent_next;
	logic        cmp_in_next;
	logic        cmp_run_next;

	// Overpressure dwell timer. It saturates one past the limit so that
	// only an interval strictly longer than the limit counts.
	wire op_expired   = op_cnt_reg > OVERPRESS_CYC;
	wire op_saturated = op_cnt_reg == OVERPRESS_CYC + 32'h1;

	always_comb begin
		if (alarm_one) begin
			op_cnt_next = 32'h0; // [RULE_17]
		end else if (op_saturated) begin
			op_cnt_next = op_cnt_reg;
		end else begin
			op_cnt_next = op_cnt_reg + 32'h1; // [RULE_01]
		end
	end

	// Vent entry conditions; the final vent outranks the intermediate one.
	wire final_req = mid_level | source_empty; // [RULE_06]
	wire inter_req = op_expired | overpress; // [RULE_01] [RULE_02]
	wire recovering = (state_reg == TVR_RECOVER) | (state_reg == TVR_SELF_EVAC);
	wire busy       = (state_reg != TVR_IDLE) & (state_reg != TVR_ERROR);

	// Next state.
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			TVR_IDLE: begin
				if (start_press & ~stop_open & auto_en_reg) begin
					state_next = TVR_RECOVER; // [RULE_09]
				end
			end
			TVR_RECOVER: begin
				if (final_req) begin
					state_next = TVR_FINAL_VENT; // [RULE_06]
				end else if (inter_req) begin
					state_next = TVR_INTER_VENT; // [RULE_01] [RULE_02]
				end else if (compressor_run_out_o & accum_liquid) begin
					state_next = TVR_SELF_EVAC; // [RULE_11]
				end
			end
			TVR_SELF_EVAC: begin
				if (final_req) begin
					state_next = TVR_FINAL_VENT;
				end else if (inter_req) begin
					state_next = TVR_INTER_VENT;
				end else if (~accum_liquid) begin
					state_next = TVR_RECOVER;
				end
			end
			TVR_INTER_VENT: begin
				if (final_req) begin
					state_next = TVR_FINAL_VENT;
				end else if (alarm_one) begin
					state_next = TVR_RECOVER; // [RULE_05]
				end
			end
			TVR_FINAL_VENT: begin
				if (~alarm_two) begin
					if (low_level) begin
						state_next = TVR_PUMP_OUT; // [RULE_07] [RULE_08]
					end else if (source_empty) begin
						state_next = TVR_IDLE;
					end else begin
						state_next = TVR_RECOVER;
					end
				end
			end
			TVR_PUMP_OUT: begin
				state_next = TVR_PUMP_OUT;
			end
			TVR_ERROR: begin
				if (err_clr_reg & ~cmp_fault) begin
					state_next = TVR_IDLE;
				end
			end
			default: begin
				state_next = TVR_IDLE;
			end
		endcase
		// A fault outranks a stop and any sequencing step except the start from idle.
		if (busy & stop_open) begin
			state_next = TVR_IDLE; // [RULE_15]
		end
		if (busy & cmp_fault) begin
			state_next = TVR_ERROR; // [RULE_16]
		end
	end

	// Output levels follow the next state so every output is a flop.
	wire next_recovering = (state_next == TVR_RECOVER) | (state_next == TVR_SELF_EVAC);
	wire next_venting    = (state_next == TVR_INTER_VENT) | (state_next == TVR_FINAL_VENT);
	wire cmp_engage      = (state_next == TVR_RECOVER) & (compressor_run_out_o | inlet_low);

	always_comb begin
		// Vent states hold inlet and compressor off.
		inlet_next   = next_recovering; // [RULE_03] [RULE_09] [RULE_12]
		cmp_run_next = cmp_engage | (state_next == TVR_SELF_EVAC); // [RULE_03] [RULE_10] [RULE_11]
		cmp_in_next  = cmp_engage; // [RULE_10] [RULE_11]
		// The valve closes when the tank warms, since venting then loses agent.
		vent_next    = next_venting & tank_cold; // [RULE_04] [RULE_13]
	end

	// Status outputs follow the next state as well, so the lamps never lag the valves.
	wire processing_next = (state_next != TVR_IDLE) & (state_next != TVR_ERROR);
	wire pump_next       = state_next == TVR_PUMP_OUT;
	wire error_next      = state_next == TVR_ERROR;

	// A clear in the same cycle as a fault loses: the state stays in error.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			state_reg  <= TVR_IDLE;
			op_cnt_reg <= 32'h0;
		end else begin
			state_reg  <= state_next;
			op_cnt_reg <= op_cnt_next;
		end
	end

	// The inlet stays open through self-evacuation so source flow keeps reaching the filters.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			inlet_valve_out_o <= 1'h0;
		end else begin
			inlet_valve_out_o <= inlet_next;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			vent_valve_out_o <= 1'h0;
		end else begin
			vent_valve_out_o <= vent_next; // [RULE_14]
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			compressor_inlet_valve_out_o <= 1'h0;
		end else begin
			compressor_inlet_valve_out_o <= cmp_in_next;
		end
	end

	// The compressor keeps running with its inlet shut until the accumulator is dry.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			compressor_run_out_o <= 1'h0;
		end else begin
			compressor_run_out_o <= cmp_run_next;
		end
	end

	// Processing drives the panel lamp and is low in idle and error alike.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			processing_o <= 1'h0;
		end else begin
			processing_o <= processing_next;
		end
	end

	// The pump-out sequence itself lies outside this block; the request holds until a stop or a compressor fault.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			pump_out_request_o <= 1'h0;
		end else begin
			pump_out_request_o <= pump_next; // [RULE_08]
		end
	end

	// Only a clear with the fault switch closed leaves error.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			error_o <= 1'h0;
		end else begin
			error_o <= error_next; // [RULE_16]
		end
	end

	// Register port decode.
	wire ctrl_sel   = reg_addr_i == CTRL_OFS;
	wire status_sel = reg_addr_i == STATUS_OFS;
	wire ctrl_wr    = reg_we_i & ctrl_sel;

	logic [DATA_W-1:0] ctrl_word;
	logic [DATA_W-1:0] status_word;
	logic [DATA_W-1:0] rd_mux;

	always_comb begin
		ctrl_word                    = '0;
		ctrl_word[CTRL_AUTO_EN_BIT]  = auto_en_reg;
		status_word                  = '0;
		status_word[STAT_STATE_LSB +: 3] = state_reg;
		status_word[STAT_EXPIRED_BIT]  = op_expired;
		status_word[STAT_INLET_BIT]    = inlet_valve_out_o;
		status_word[STAT_VENT_BIT]     = vent_valve_out_o;
		status_word[STAT_CMP_IN_BIT]   = compressor_inlet_valve_out_o;
		status_word[STAT_CMP_RUN_BIT]  = compressor_run_out_o;
		status_word[STAT_PUMP_REQ_BIT] = pump_out_request_o;
		status_word[STAT_ERROR_BIT]    = error_o;
	end

	assign rd_mux = ctrl_sel   ? ctrl_word :
	                status_sel ? status_word : '0;

	// Auto enable resets high so the start button works straight after power-up.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			auto_en_reg <= CTRL_AUTO_EN_RST;
		end else if (ctrl_wr) begin
			auto_en_reg <= reg_wdata_i[CTRL_AUTO_EN_BIT];
		end
	end

	// The clear is a one-cycle pulse; bit one always reads back as zero.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			err_clr_reg <= 1'h0;
		end else begin
			err_clr_reg <= ctrl_wr & reg_wdata_i[CTRL_ERR_CLR_BIT];
		end
	end

	// Read data stand for exactly the cycle after the read strobe.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			reg_rdata_o <= '0;
		end else begin
			reg_rdata_o <= reg_re_i ? rd_mux : '0;
		end
	end

endmodule : tvr_sequencer
`default_nettype wire

// *** testbench/tvr_sva.sv ***
// Concurrent checks on the sequencer's discrete outputs.
`timescale 1ns/1ns
`default_nettype none
module tvr_sva (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic tank_cold_alarm_in_i,
	input wire logic tank_pressure_alarm_two_in_i,
	input wire logic tank_pressure_alarm_one_in_i,
	input wire logic start_button_in_i,
	input wire logic stop_button_in_i,
	input wire logic tank_low_level_in_i,
	input wire logic compressor_pressure_fault_in_i,
	input wire logic inlet_valve_out_o,
	input wire logic vent_valve_out_o,
	input wire logic compressor_inlet_valve_out_o,
	input wire logic compressor_run_out_o,
	input wire logic processing_o,
	input wire logic pump_out_request_o,
	input wire logic error_o
);
	// Pins reach the outputs through two synchroniser stages and the output flop; the checks look back two cycles.
	wire logic end_w;
	assign end_w = !tank_cold_alarm_in_i | tank_pressure_alarm_one_in_i | !tank_pressure_alarm_two_in_i
		| !stop_button_in_i | !compressor_pressure_fault_in_i;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);
	property p_start; $rose(processing_o) |-> $past(start_button_in_i, 2) && inlet_valve_out_o; endproperty
	a_start: assert property (p_start) else $error("run began without start");
	property p_cmp; $rose(compressor_inlet_valve_out_o) |-> compressor_run_out_o && inlet_valve_out_o; endproperty
	a_cmp: assert property (p_cmp) else $error("compressor inlet without compressor");
	property p_acc; $fell(compressor_inlet_valve_out_o) && inlet_valve_out_o |-> compressor_run_out_o; endproperty
	a_acc: assert property (p_acc) else $error("compressor stopped in self evacuation");
	property p_excl; vent_valve_out_o |-> !inlet_valve_out_o && !compressor_run_out_o; endproperty
	a_excl: assert property (p_excl) else $error("inlet active while venting");
	property p_cold; $rose(vent_valve_out_o) |-> $past(tank_cold_alarm_in_i, 2); endproperty
	a_cold: assert property (p_cold) else $error("vent opened while tank warm");
	property p_hold; $fell(vent_valve_out_o) |-> $past(end_w, 2); endproperty
	a_hold: assert property (p_hold) else $error("vent closed without cause");
	property p_stop; $fell(stop_button_in_i) && processing_o |-> ##[1:3] !processing_o; endproperty
	a_stop: assert property (p_stop) else $error("stop did not end the run");
	property p_fault; $rose(error_o) |-> !$past(compressor_pressure_fault_in_i, 2) && !processing_o; endproperty
	a_fault: assert property (p_fault) else $error("error without fault");
	property p_pump; $rose(pump_out_request_o) |-> $past(tank_low_level_in_i, 2) && !vent_valve_out_o; endproperty
	a_pump: assert property (p_pump) else $error("pump out without low level");
endmodule : tvr_sva
`default_nettype wire

// *** testbench/tvr_plant.sv ***
// Discrete switch bank standing across the sequencer's input pins.
`timescale 1ns/1ns
`default_nettype none
module tvr_plant (
	input  wire logic [11:0] cmd_i,
	output logic      [11:0] pins_o
);
	// Contacts are ideal; bounce is left out, the sequencer is what is under test.
	assign pins_o = cmd_i;
endmodule : tvr_plant
`default_nettype wire

// *** testbench/tb.sv ***
// Self-checking bench for the tank vent recovery sequencer.
`timescale 1ns/1ns
`default_nettype none
module tb;
	import tvr_pkg::*;
	logic              clk_i = 1'b0;
	logic              srst_i = 1'b1;
	logic [11:0]       sw = 12'hCB6;
	logic [11:0]       pins;
	logic [ADDR_W-1:0] reg_addr_i = 4'h0;
	logic [DATA_W-1:0] reg_wdata_i = 32'h0;
	logic              reg_we_i = 1'b0;
	logic              reg_re_i = 1'b0;
	logic [DATA_W-1:0] reg_rdata_o;
	logic [31:0]       r;
	logic inlet_valve_out_o, vent_valve_out_o, compressor_inlet_valve_out_o, compressor_run_out_o;
	logic processing_o, pump_out_request_o, error_o;
	wire logic tank_cold_alarm_in_i, tank_pressure_alarm_two_in_i, tank_pressure_alarm_one_in_i;
	wire logic start_button_in_i, stop_button_in_i, source_vacuum_in_i, inlet_pressure_low_in_i;
	wire logic accumulator_level_in_i, tank_low_level_in_i, tank_mid_level_in_i;
	wire logic tank_overpressure_in_i, compressor_pressure_fault_in_i;
	int fail_count = 0;
	int total_checks = 0;
	assign {compressor_pressure_fault_in_i, tank_overpressure_in_i, tank_mid_level_in_i, tank_low_level_in_i,
		accumulator_level_in_i, inlet_pressure_low_in_i, source_vacuum_in_i, stop_button_in_i,
		start_button_in_i, tank_pressure_alarm_one_in_i, tank_pressure_alarm_two_in_i, tank_cold_alarm_in_i} = pins;
	tvr_plant u_plant (.cmd_i(sw), .pins_o(pins));
	tvr_sequencer #(.OVERPRESS_CYC(32'h14)) u_dut (
		.clk_i                         (clk_i),
		.srst_i                        (srst_i),
		.tank_cold_alarm_in_i          (tank_cold_alarm_in_i),
		.tank_pressure_alarm_two_in_i  (tank_pressure_alarm_two_in_i),
		.tank_pressure_alarm_one_in_i  (tank_pressure_alarm_one_in_i),
		.start_button_in_i             (start_button_in_i),
		.stop_button_in_i              (stop_button_in_i),
		.source_vacuum_in_i            (source_vacuum_in_i),
		.inlet_pressure_low_in_i       (inlet_pressure_low_in_i),
		.accumulator_level_in_i        (accumulator_level_in_i),
		.tank_low_level_in_i           (tank_low_level_in_i),
		.tank_mid_level_in_i           (tank_mid_level_in_i),
		.tank_overpressure_in_i        (tank_overpressure_in_i),
		.compressor_pressure_fault_in_i(compressor_pressure_fault_in_i),
		.reg_addr_i                    (reg_addr_i),
		.reg_wdata_i                   (reg_wdata_i),
		.reg_we_i                      (reg_we_i),
		.reg_re_i                      (reg_re_i),
		.reg_rdata_o                   (reg_rdata_o),
		.inlet_valve_out_o             (inlet_valve_out_o),
		.vent_valve_out_o              (vent_valve_out_o),
		.compressor_inlet_valve_out_o  (compressor_inlet_valve_out_o),
		.compressor_run_out_o          (compressor_run_out_o),
		.processing_o                  (processing_o),
		.pump_out_request_o            (pump_out_request_o),
		.error_o                       (error_o)
	);
	always #50 clk_i = ~clk_i;
	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: %h not %h", $time, got, exp);
		end
	endtask : chk_reg
	task automatic chk_out(input logic [6:0] exp);
		logic [6:0] got;
		#1;
		got = {inlet_valve_out_o, vent_valve_out_o, compressor_inlet_valve_out_o, compressor_run_out_o,
			processing_o, pump_out_request_o, error_o};
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: outputs %h not %h", $time, got, exp);
		end
	endtask : chk_out
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_i);
		reg_we_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge clk_i);
		reg_we_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk_i);
		reg_re_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge clk_i);
		reg_re_i <= 1'b0;
		#1 d = reg_rdata_o;
	endtask : rd
	task automatic st(input logic [31:0] e);
		rd(STATUS_OFS, r);
		chk_reg(r & 32'h7, e);
	endtask : st
	task automatic put(input logic [11:0] v);
		@(posedge clk_i);
		sw <= v;
		repeat (4) @(posedge clk_i);
	endtask : put
	task automatic go;
		put(12'hCBE);
		put(12'hCB6);
	endtask : go
	task automatic home;
		put(12'hCA6);
		chk_out(7'h00);
		put(12'hCB6);
	endtask : home
	task automatic t_regs;
		rd(CTRL_OFS, r);
		chk_reg(r, 32'h1);
		wr(STATUS_OFS, 32'hFFFF_FFFF);
		rd(STATUS_OFS, r);
		chk_reg(r, 32'h0);
		rd(4'h8, r);
		chk_reg(r, 32'h0);
		wr(CTRL_OFS, 32'h0);
		go;
		chk_out(7'h00);
		wr(CTRL_OFS, 32'h1);
	endtask : t_regs
	task automatic t_recover;
		put(12'hCBE);
		chk_out(7'h44);
		put(12'hCF6);
		chk_out(7'h5C);
		put(12'hC76);
		chk_out(7'h4C);
		st(32'h2);
		put(12'hCF6);
		chk_out(7'h5C);
		home;
	endtask : t_recover
	task automatic t_over;
		go;
		put(12'hCF6);
		put(12'h8F2);
		chk_out(7'h04);
		st(32'h3);
		put(12'h8F3);
		chk_out(7'h24);
		put(12'hCF3);
		chk_out(7'h24);
		put(12'hCB7);
		chk_out(7'h44);
		home;
	endtask : t_over
	task automatic t_timer;
		go;
		put(12'hCB2);
		repeat (8) @(posedge clk_i);
		put(12'hCB6);
		put(12'hCB2);
		repeat (10) @(posedge clk_i);
		chk_out(7'h44);
		repeat (16) @(posedge clk_i);
		chk_out(7'h04);
		put(12'hCB6);
		home;
	endtask : t_timer
	task automatic t_final;
		go;
		put(12'hEB6);
		st(32'h4);
		put(12'hEB7);
		chk_out(7'h24);
		put(12'hFB5);
		chk_out(7'h06);
		home;
		go;
		put(12'hC96);
		st(32'h4);
		put(12'hC94);
		chk_out(7'h00);
		put(12'hCB6);
	endtask : t_final
	task automatic t_fault;
		go;
		put(12'h4B6);
		chk_out(7'h01);
		st(32'h6);
		put(12'hCB6);
		wr(CTRL_OFS, 32'h3);
		repeat (2) @(posedge clk_i);
		chk_out(7'h00);
	endtask : t_fault
	task automatic tally_and_finish;
		if (fail_count == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (20) @(posedge clk_i);
		srst_i <= 1'b0;
		t_regs;
		t_recover;
		t_over;
		t_timer;
		t_final;
		t_fault;
		tally_and_finish;
	end
	// The tests need well under a thousand cycles; this leaves ample margin.
	initial begin
		#300000;
		fail_count++;
		tally_and_finish;
	end
endmodule : tb
bind tvr_sequencer tvr_sva u_sva (
	.clk_i                         (clk_i),
	.srst_i                        (srst_i),
	.tank_cold_alarm_in_i          (tank_cold_alarm_in_i),
	.tank_pressure_alarm_two_in_i  (tank_pressure_alarm_two_in_i),
	.tank_pressure_alarm_one_in_i  (tank_pressure_alarm_one_in_i),
	.start_button_in_i             (start_button_in_i),
	.stop_button_in_i              (stop_button_in_i),
	.tank_low_level_in_i           (tank_low_level_in_i),
	.compressor_pressure_fault_in_i(compressor_pressure_fault_in_i),
	.inlet_valve_out_o             (inlet_valve_out_o),
	.vent_valve_out_o              (vent_valve_out_o),
	.compressor_inlet_valve_out_o  (compressor_inlet_valve_out_o),
	.compressor_run_out_o          (compressor_run_out_o),
	.processing_o                  (processing_o),
	.pump_out_request_o            (pump_out_request_o),
	.error_o                       (error_o)
);
`default_nettype wire
